// File: logic/see_pkg.sv
// Purpose: Shared constants of the two-wire serial memory link
// Assumes: Core clock of 25 MHz on both ends
// Notes:   Times in ns, counts derived from them
package see_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  // Longest program time, so the count rounds down
  localparam int unsigned PROG_TIME_NS   = 5000000;
  localparam int unsigned PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;
  // Shortest serial clock period, so a quarter rounds up
  localparam int unsigned SCL_PERIOD_NS  = 10000;
  localparam int unsigned SCL_QTR_CYCLES =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          AW             = 8;
  localparam int          DW             = 8;
  localparam int          DEPTH          = 256;
  localparam int          PAGE_BITS      = 3;
  localparam int          PAGE_LEN       = 8;
  localparam int          PCW            = 24;
  localparam int          QCW            = 8;
  localparam logic [3:0]  DEV_TYPE       = 4'hA;
  localparam logic [3:0]  BIT_ACK        = 4'h8;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic        RW_READ        = 1'b1;
  localparam logic [1:0]  QTR_SAMPLE     = 2'h2;
  localparam logic [1:0]  QTR_LAST       = 2'h3;
  typedef logic [DW-1:0] see_byte_t;
endpackage

// File: logic/see_if.sv
// Purpose: Open-drain two-wire link between master and memory
// Assumes: Pull-up on the data wire
// Notes:   Oe high means that end pulls the wire low if its out level is low
`timescale 1ns/10ps
interface see_if;
  logic scl;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic sda;

  // Wired-AND with pull-up
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

  modport host (output scl, sdaHostOut, sdaHostOe, input sda);
  modport dev  (input scl, sda, output sdaDevOut, sdaDevOe);
endinterface

// File: logic/see_eeprom_dev.sv
// Purpose: Memory end of the two-wire link with 256 x 8 storage
// Assumes: Serial clock far slower than core_clk, sampled as a pin
// Notes:   Storage is flip-flops, cleared by resetn
`timescale 1ns/10ps
// Function
// - Sample on clock rise, drive on fall
// - Data pin only pulled low or released
// - Inhibit pin high blocks programming of bytes received while it is high
// - 256 words of eight bits, byte addressed
// - Master keeps data stable while clock high
// - Data fall with clock high is start
// - Data rise with clock high is stop
// - Acknowledge each received byte on ninth pulse
// - Device byte begins with fixed 1010 pattern
// - Next three bits match select pins
// - Match acknowledges, mismatch goes to standby
// - Eighth bit chooses read or write
// - Byte write then stop starts programming
// - Ignore bus entirely while programming
// - Page write takes up to eight bytes
// - Data bytes advance low three address bits
// - No acknowledge while busy; master polls
// - Counter keeps last address plus one
// - Reads wrap from top to address zero
// - Current read: send byte, master nacks
// - Random read: dummy write, repeated start
// - Master ack continues, nack ends reading
// - Master times programming from stop
module see_eeprom_dev
  import see_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  // Two-wire link
  see_if.dev              bus,
  // Board straps
  input  wire logic [2:0] hardwiredSelectPins,
  input  wire logic       writeInhibit,
  // Status
  output logic            progBusy
);

  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK, D_PROG} see_dstate_e;
  typedef enum logic [1:0] {P_DEV, P_WADDR, P_DATA} see_phase_e;

  typedef struct packed {
    logic [2:0]                    sclSync;
    logic [2:0]                    sdaSync;
    logic [2:0]                    selMeta;
    logic [2:0]                    selSync;
    logic                          wpMeta;
    logic                          wpSync;
    see_dstate_e                   state;
    see_phase_e                    phase;
    logic                          readOp;
    logic                          mAck;
    logic [3:0]                    bitCnt;
    see_byte_t                     shift;
    logic [AW-1:0]                 wordAddr;
    logic [AW-1:0]                 pageAddr;
    logic [PAGE_LEN-1:0][DW-1:0]   pageBuf;
    logic [PAGE_LEN-1:0]           pageValid;
    logic [PCW-1:0]                progCnt;
    logic                          sdaLow;
    logic [DEPTH-1:0][DW-1:0]      mem;
  } see_dev_s;

  see_dev_s r_reg;
  see_dev_s r_next;
  logic     sclRise;
  logic     sclFall;
  logic     sclHigh;
  logic     startSeen;
  logic     stopSeen;

  // Write address stays inside its page
  function automatic logic [AW-1:0] see_page_inc(input logic [AW-1:0] a);
    return {a[AW-1:PAGE_BITS], a[PAGE_BITS-1:0] + 3'h1};
  endfunction

  // ----------------------------------------------------------------
  // Link edge and condition decode
  // ----------------------------------------------------------------
  // Stage 0 of each synchroniser feeds stage 1 only
  assign sclRise   = r_reg.sclSync[1] & ~r_reg.sclSync[2];
  assign sclFall   = ~r_reg.sclSync[1] & r_reg.sclSync[2];
  assign sclHigh   = r_reg.sclSync[1] & r_reg.sclSync[2];
  assign startSeen = sclHigh & r_reg.sdaSync[2] & ~r_reg.sdaSync[1];
  assign stopSeen  = sclHigh & ~r_reg.sdaSync[2] & r_reg.sdaSync[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic loadTx;
    loadTx = 1'b0;
    r_next = r_reg;
    r_next.sclSync = {r_reg.sclSync[1:0], bus.scl};
    r_next.sdaSync = {r_reg.sdaSync[1:0], bus.sda};
    r_next.selMeta = hardwiredSelectPins;
    r_next.selSync = r_reg.selMeta;
    r_next.wpMeta  = writeInhibit;
    r_next.wpSync  = r_reg.wpMeta;

    if (r_reg.state == D_PROG) begin
      // Deaf to the bus, so polling gets no acknowledge
      r_next.sdaLow = 1'b0;
      r_next.progCnt = r_reg.progCnt + 24'h1;
      if (r_reg.progCnt == PCW'(PROG_CYC - 1)) begin
        for (int i = 0; i < PAGE_LEN; i++) begin
          if (r_reg.pageValid[i]) begin
            r_next.mem[{r_reg.pageAddr[AW-1:PAGE_BITS], PAGE_BITS'(i)}] = r_reg.pageBuf[i];
          end
        end
        r_next.pageValid = '0;
        r_next.state = D_IDLE;
      end
    end else if (startSeen) begin
      // Abandons any byte in flight and any unfinished page
      r_next.state     = D_RX;
      r_next.phase     = P_DEV;
      r_next.bitCnt    = 4'h0;
      r_next.sdaLow    = 1'b0;
      r_next.readOp    = 1'b0;
      r_next.pageValid = '0;
    end else if (stopSeen) begin
      r_next.sdaLow  = 1'b0;
      r_next.progCnt = '0;
      // Read or empty write returns to standby
      r_next.state = (|r_reg.pageValid) ? D_PROG : D_IDLE;
    end else begin
      case (r_reg.state)
        D_RX: begin
          if (sclRise) begin
            r_next.shift  = {r_reg.shift[DW-2:0], r_reg.sdaSync[1]};
            r_next.bitCnt = r_reg.bitCnt + 4'h1;
          end else if (sclFall && r_reg.bitCnt == BIT_ACK) begin
            r_next.state  = D_ACK;
            r_next.sdaLow = 1'b1;
            r_next.bitCnt = 4'h0;
            case (r_reg.phase)
              P_DEV: begin
                if (r_reg.shift[7:4] == DEV_TYPE && r_reg.shift[3:1] == r_reg.selSync) begin
                  r_next.readOp = (r_reg.shift[0] == RW_READ);
                  r_next.phase  = (r_reg.shift[0] == RW_READ) ? P_DATA : P_WADDR;
                end else begin
                  r_next.state  = D_IDLE;
                  r_next.sdaLow = 1'b0;
                end
              end
              P_WADDR: begin
                r_next.wordAddr = r_reg.shift;
                r_next.pageAddr = r_reg.shift;
                r_next.phase    = P_DATA;
              end
              P_DATA: begin
                // Protected bytes are acknowledged but never queued
                if (!r_reg.wpSync) begin
                  r_next.pageBuf[r_reg.wordAddr[PAGE_BITS-1:0]]   = r_reg.shift;
                  r_next.pageValid[r_reg.wordAddr[PAGE_BITS-1:0]] = 1'b1;
                end
                r_next.wordAddr = see_page_inc(r_reg.wordAddr);
              end
              default: begin
                r_next.state  = D_IDLE;
                r_next.sdaLow = 1'b0;
              end
            endcase
          end
        end
        D_ACK: begin
          if (sclFall) begin
            r_next.sdaLow = 1'b0;
            r_next.state  = D_RX;
            loadTx        = r_reg.readOp;
          end
        end
        D_TX: begin
          if (sclRise) begin
            r_next.bitCnt = r_reg.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (r_reg.bitCnt == BIT_ACK) begin
              r_next.sdaLow = 1'b0;
              r_next.state  = D_TXACK;
            end else begin
              r_next.sdaLow = ~r_reg.shift[DW-1];
              r_next.shift  = {r_reg.shift[DW-2:0], 1'b0};
            end
          end
        end
        D_TXACK: begin
          if (sclRise) begin
            r_next.mAck = ~r_reg.sdaSync[1];
          end else if (sclFall) begin
            // Nack leaves the line free for the stop
            loadTx = r_reg.mAck;
            r_next.state = D_IDLE;
          end
        end
        default: begin
          r_next.sdaLow = 1'b0;
          r_next.state  = D_IDLE;
        end
      endcase
    end

    if (loadTx) begin
      r_next.state    = D_TX;
      r_next.bitCnt   = 4'h0;
      r_next.sdaLow   = ~r_reg.mem[r_reg.wordAddr][DW-1];
      r_next.shift    = {r_reg.mem[r_reg.wordAddr][DW-2:0], 1'b0};
      // Plain 8-bit add wraps the top word to zero
      r_next.wordAddr = r_reg.wordAddr + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      // Link synchronisers start at the idle level, so no false edge follows reset
      r_reg         <= '0;
      r_reg.sclSync <= '1;
      r_reg.sdaSync <= '1;
    end else if (clkEn) begin
      r_reg <= r_next;
    end
  end

  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOe  = r_reg.sdaLow;
  assign progBusy      = (r_reg.state == D_PROG);

endmodule // see_eeprom_dev

// File: logic/see_master_host.sv
// Purpose: Master end of the two-wire link, one command at a time
// Assumes: Memory end samples the serial clock with its own core clock
// Notes:   Serial clock made by dividing core_clk into quarter periods
`timescale 1ns/10ps
module see_master_host
  import see_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  // Two-wire link
  see_if.host             bus,
  // Command
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic       cmdRead,
  input  wire logic       cmdRandom,
  input  wire logic [2:0] cmdSel,
  input  wire logic [7:0] cmdAddr,
  input  wire logic [3:0] cmdCount,
  // Write data stream
  input  wire logic       wrValid,
  input  wire see_byte_t  wrData,
  output logic            wrReady,
  // Read data and completion
  output logic            rdValid,
  output see_byte_t       rdData,
  output logic            done,
  output logic            nack
);

  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_WAIT, H_STOP} see_hstate_e;
  typedef enum logic [2:0] {G_DEVW, G_ADDR, G_WDATA, G_DEVR, G_RDATA} see_stage_e;

  typedef struct packed {
    logic [1:0]    sdaSync;
    logic [QCW-1:0] divCnt;
    logic [1:0]    quarter;
    see_hstate_e   state;
    see_stage_e    stage;
    logic [3:0]    bitCnt;
    see_byte_t     shift;
    logic [3:0]    remain;
    logic          rnw;
    logic [2:0]    sel;
    see_byte_t     addr;
    logic          ackBit;
    logic          sclReg;
    logic          sdaLow;
    see_byte_t     rdData;
    logic          rdValid;
    logic          done;
    logic          nack;
  } see_host_s;

  see_host_s r_reg;
  see_host_s r_next;
  logic      tick;

  function automatic see_byte_t see_dev_byte(input logic [2:0] s, input logic rd);
    return {DEV_TYPE, s, rd};
  endfunction

  assign tick = (r_reg.divCnt == QCW'(SCL_QTR_CYCLES - 1));

  always_comb begin
    logic inHigh;
    inHigh = 1'b0;
    r_next = r_reg;
    r_next.rdValid = 1'b0;
    r_next.done    = 1'b0;
    r_next.sdaSync = {r_reg.sdaSync[0], bus.sda};
    if (r_reg.state != H_IDLE && r_reg.state != H_WAIT) begin
      r_next.divCnt  = tick ? '0 : r_reg.divCnt + 8'h01;
      r_next.quarter = tick ? r_reg.quarter + 2'h1 : r_reg.quarter;
    end

    case (r_reg.state)
      H_IDLE: begin
        if (cmdValid) begin
          // Pulses stay cleared, so done stands one cycle even on a back-to-back take
          r_next.rnw = cmdRead;
          r_next.sel = cmdSel;
          r_next.addr = cmdAddr;
          r_next.remain = cmdCount;
          r_next.nack = 1'b0;
          r_next.divCnt = '0;
          r_next.quarter = 2'h0;
          r_next.state = H_START;
          // Random read starts with a dummy write of the address
          r_next.stage = (cmdRead && !cmdRandom) ? G_DEVR : G_DEVW;
        end
      end
      H_START: begin
        if (tick && r_reg.quarter == QTR_LAST) begin
          r_next.state  = H_TX;
          r_next.bitCnt = 4'h0;
          r_next.shift  = see_dev_byte(r_reg.sel, r_reg.stage == G_DEVR);
        end
      end
      H_TX: begin
        if (tick && r_reg.quarter == QTR_SAMPLE) begin
          r_next.ackBit = r_reg.sdaSync[1];
        end else if (tick && r_reg.quarter == QTR_LAST) begin
          if (r_reg.bitCnt != BIT_ACK) begin
            r_next.bitCnt = r_reg.bitCnt + 4'h1;
            r_next.shift  = {r_reg.shift[DW-2:0], 1'b0};
          end else if (r_reg.ackBit) begin
            // Busy or absent device; caller polls again
            r_next.nack  = 1'b1;
            r_next.state = H_STOP;
          end else begin
            case (r_reg.stage)
              G_DEVW: begin
                r_next.stage  = G_ADDR;
                r_next.shift  = r_reg.addr;
                r_next.bitCnt = 4'h0;
              end
              G_ADDR: begin
                r_next.stage = r_reg.rnw ? G_DEVR : G_WDATA;
                r_next.state = r_reg.rnw ? H_START : H_WAIT;
              end
              G_WDATA: begin
                r_next.remain = r_reg.remain - 4'h1;
                r_next.state  = (r_reg.remain == 4'h0) ? H_STOP : H_WAIT;
              end
              G_DEVR: begin
                r_next.stage  = G_RDATA;
                r_next.state  = H_RX;
                r_next.bitCnt = 4'h0;
              end
              default: r_next.state = H_STOP;
            endcase
          end
        end
      end
      H_WAIT: begin
        if (wrValid) begin
          r_next.shift  = wrData;
          r_next.bitCnt = 4'h0;
          r_next.state  = H_TX;
        end
      end
      H_RX: begin
        if (tick && r_reg.quarter == QTR_SAMPLE && r_reg.bitCnt != BIT_ACK) begin
          r_next.shift = {r_reg.shift[DW-2:0], r_reg.sdaSync[1]};
        end else if (tick && r_reg.quarter == QTR_LAST) begin
          r_next.bitCnt = r_reg.bitCnt + 4'h1;
          if (r_reg.bitCnt == BIT_LAST) begin
            r_next.rdData  = r_reg.shift;
            r_next.rdValid = 1'b1;
          end else if (r_reg.bitCnt == BIT_ACK) begin
            r_next.bitCnt = 4'h0;
            r_next.remain = r_reg.remain - 4'h1;
            r_next.state  = (r_reg.remain == 4'h0) ? H_STOP : H_RX;
          end
        end
      end
      H_STOP: begin
        // Programming time is counted by the caller from here
        if (tick && r_reg.quarter == QTR_LAST) begin
          r_next.state = H_IDLE;
          r_next.done  = 1'b1;
        end
      end
      default: r_next.state = H_IDLE;
    endcase

    // Pin levels follow the quarter now entered
    inHigh = (r_next.quarter == 2'h1) || (r_next.quarter == QTR_SAMPLE);
    case (r_next.state)
      H_IDLE: begin
        r_next.sclReg = 1'b1;
        r_next.sdaLow = 1'b0;
      end
      H_WAIT: begin
        r_next.sclReg = 1'b0;
        r_next.sdaLow = 1'b0;
      end
      H_START: begin
        r_next.sclReg = inHigh;
        r_next.sdaLow = r_next.quarter[1];
      end
      H_STOP: begin
        r_next.sclReg = (r_next.quarter != 2'h0);
        r_next.sdaLow = ~r_next.quarter[1];
      end
      H_TX: begin
        r_next.sclReg = inHigh;
        r_next.sdaLow = (r_next.bitCnt != BIT_ACK) & ~r_next.shift[DW-1];
      end
      default: begin
        r_next.sclReg = inHigh;
        r_next.sdaLow = (r_next.bitCnt == BIT_ACK) & (r_next.remain != 4'h0);
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      r_reg        <= '0;
      r_reg.sclReg <= 1'b1;
    end else if (clkEn) begin
      r_reg <= r_next;
    end
  end

  assign bus.scl        = r_reg.sclReg;
  assign bus.sdaHostOut = 1'b0;
  assign bus.sdaHostOe  = r_reg.sdaLow;
  assign cmdReady       = (r_reg.state == H_IDLE);
  assign wrReady        = (r_reg.state == H_WAIT);
  assign rdValid        = r_reg.rdValid;
  assign rdData         = r_reg.rdData;
  assign done           = r_reg.done;
  assign nack           = r_reg.nack;

endmodule // see_master_host

// File: verification/see_link_monitor.sv
// Purpose: Protocol checks on the two-wire link between both ends
// Assumes: One core_clk domain, synchronous active-low reset
// Notes:   Bit position counts scl rises since the last start, stop or ninth pulse
`timescale 1ns/10ps
module see_link_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link
  input wire logic scl,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe,
  input wire logic sda
);
  logic       sclD_reg;
  logic       sdaD_reg;
  logic [3:0] bitPos_reg;
  logic [1:0] byteCnt_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Bit and byte position
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    sclD_reg <= scl;
    sdaD_reg <= sda;
    // Start and stop both restart the count, so either comes at position one
    if (!resetn || (scl && sclD_reg && (sdaD_reg != sda))) begin
      bitPos_reg  <= 4'h0;
      byteCnt_reg <= 2'h0;
    end else if (scl && !sclD_reg) begin
      bitPos_reg <= (bitPos_reg == 4'h8) ? 4'h0 : bitPos_reg + 4'h1;
      if (bitPos_reg == 4'h8 && byteCnt_reg != 2'h3) begin
        byteCnt_reg <= byteCnt_reg + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Ack stands until the ninth pulse is high; a read may keep the wire low after it
  sequence ackHold;
    sdaDevOe throughout (##[1:300] (scl && bitPos_reg == 4'h0));
  endsequence

  chk_dev_open_drain: assert property (sdaDevOe |-> !sdaDevOut)
    else $error("memory end drives the data wire high");
  chk_host_open_drain: assert property (sdaHostOe |-> !sdaHostOut)
    else $error("master end drives the data wire high");
  chk_dev_clk_low: assert property ($changed(sdaDevOe) |-> !scl)
    else $error("memory end changed data while clock high");
  chk_data_stable: assert property (scl && $past(scl) && $changed(sda) |-> bitPos_reg == 4'h1)
    else $error("data changed with clock high inside a byte");
  chk_start_by_host: assert property ($fell(sda) && scl |-> sdaHostOe && !sdaDevOe)
    else $error("start not made by the master");
  chk_stop_released: assert property ($rose(sda) && scl |-> !sdaDevOe [*8])
    else $error("memory end drives after stop");
  chk_ack_ninth: assert property ($rose(sdaDevOe) && bitPos_reg == 4'h8 |-> ackHold)
    else $error("acknowledge not held for the ninth pulse");
  chk_addr_quiet: assert property (byteCnt_reg == 2'h0 && bitPos_reg != 4'h8 |-> !sdaDevOe)
    else $error("memory end drives during device address");
endmodule // see_link_monitor

// File: verification/tb.sv
// Purpose: Self-checking bench, master end against memory end
// Assumes: Select straps 5, program time shortened to PROG cycles
// Notes:   Expected bytes follow from page wrap and counter rules
`timescale 1ns/10ps
module tb;
  import see_pkg::*;
  localparam int unsigned PROG = 4000;
  logic       core_clk;
  logic       resetn;
  logic       cmdValid;
  logic       cmdRead;
  logic       cmdRandom;
  logic [2:0] cmdSel;
  logic [7:0] cmdAddr;
  logic [3:0] cmdCount;
  logic       wrValid;
  logic       writeInhibit;
  see_byte_t  wrData;
  see_byte_t  rdData;
  logic       cmdReady;
  logic       wrReady;
  logic       rdValid;
  logic       done;
  logic       nack;
  logic       progBusy;
  int         error_cnt;
  int         checked;
  int         cycles;
  see_byte_t  wbuf[8];
  see_byte_t  rdq[$];

  see_if link();

  see_master_host see_master_host_i (.core_clk(core_clk), .resetn(resetn),
    .clkEn(1'b1), .bus(link.host), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdRead(cmdRead), .cmdRandom(cmdRandom), .cmdSel(cmdSel), .cmdAddr(cmdAddr),
    .cmdCount(cmdCount), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
    .rdValid(rdValid), .rdData(rdData), .done(done), .nack(nack));
  see_eeprom_dev #(.PROG_CYC(PROG)) see_eeprom_dev_i (.core_clk(core_clk),
    .resetn(resetn), .clkEn(1'b1), .bus(link.dev), .hardwiredSelectPins(3'h5),
    .writeInhibit(writeInhibit), .progBusy(progBusy));
  see_link_monitor see_link_monitor_i (.core_clk(core_clk), .resetn(resetn),
    .scl(link.scl), .sdaHostOut(link.sdaHostOut), .sdaHostOe(link.sdaHostOe),
    .sdaDevOut(link.sdaDevOut), .sdaDevOe(link.sdaDevOe), .sda(link.sda));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    if (rdValid === 1'b1) rdq.push_back(rdData);
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // One command; write bytes come from wbuf, read bytes land in rdq
  task automatic run(input logic rd, input logic rnd, input logic [2:0] sel,
                     input logic [7:0] addr, input int n, input logic expNack);
    int k;
    int t;
    k = 0;
    t = 0;
    rdq.delete();
    cmdValid  <= 1'b1;
    cmdRead   <= rd;
    cmdRandom <= rnd;
    cmdSel    <= sel;
    cmdAddr   <= addr;
    cmdCount  <= 4'(n - 1);
    wrValid   <= !rd;
    wrData    <= wbuf[0];
    check("cmdReady", 8'h01, 8'(cmdReady));
    @(posedge core_clk);
    cmdValid <= 1'b0;
    do begin
      @(negedge core_clk);
      t++;
      if (wrValid === 1'b1 && wrReady === 1'b1) begin
        @(posedge core_clk);
        k++;
        wrValid <= (k < n);
        wrData  <= wbuf[k % 8];
      end
    end while (done !== 1'b1 && t < 40000);
    check("done", 8'h01, 8'(done === 1'b1));
    @(posedge core_clk);
    check("nack", 8'(expNack), 8'(nack));
    check("read count", 8'(expNack ? 0 : (rd ? n : 0)), 8'(rdq.size()));
  endtask

  task automatic wait_idle();
    int t;
    t = 0;
    while (progBusy !== 1'b0 && t < 8000) begin
      @(posedge core_clk);
      t++;
    end
    check("busy", 8'h00, 8'(progBusy));
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    resetn = 1'b0;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdRandom = 1'b0;
    cmdSel = 3'h0;
    cmdAddr = 8'h00;
    cmdCount = 4'h0;
    wrValid = 1'b0;
    wrData = 8'h00;
    writeInhibit = 1'b0;
    foreach (wbuf[i]) wbuf[i] = 8'(8'h91 + i);
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Page write crossing the page end: FE, FF, then F8
    run(1'b0, 1'b0, 3'h5, 8'hFE, 3, 1'b0);
    check("busy", 8'h01, 8'(progBusy));
    run(1'b0, 1'b0, 3'h5, 8'h00, 1, 1'b1);
    wait_idle();
    wbuf[0] = 8'h5C;
    run(1'b0, 1'b0, 3'h5, 8'h00, 1, 1'b0);
    wait_idle();
    run(1'b1, 1'b1, 3'h5, 8'hFE, 1, 1'b0);
    check("rd FE", 8'h91, rdq[0]);
    // Counter continues at FF and wraps to 00 while reading
    run(1'b1, 1'b0, 3'h5, 8'h00, 2, 1'b0);
    check("rd FF", 8'h92, rdq[0]);
    check("rd 00", 8'h5C, rdq[1]);
    run(1'b1, 1'b0, 3'h2, 8'h00, 1, 1'b1);
    writeInhibit <= 1'b1;
    wbuf[0] = 8'hE7;
    repeat (4) @(posedge core_clk);
    run(1'b0, 1'b0, 3'h5, 8'hF8, 1, 1'b0);
    check("busy", 8'h00, 8'(progBusy));
    writeInhibit <= 1'b0;
    run(1'b1, 1'b1, 3'h5, 8'hF8, 1, 1'b0);
    check("rd F8", 8'h93, rdq[0]);
    close_out();
  end
endmodule // tb
